// File: logic/sar_pkg.sv
package sar_pkg;

  // ==========================================================================
  // Stack pointer
  localparam logic [15:0] SP_RESET       = 16'h00FF;
  localparam logic [2:0]  IRQ_STACK_BYTES = 3'h5;
  localparam logic [2:0]  JSR_STACK_BYTES = 3'h2;

  // ==========================================================================
  // Address windows, inclusive bounds
  localparam logic [15:0] RAM0_LO  = 16'h0050;
  localparam logic [15:0] RAM0_HI  = 16'h044F;
  localparam logic [15:0] RAM1_LO  = 16'h0A00;
  localparam logic [15:0] RAM1_HI  = 16'h0DFF;
  localparam logic [15:0] PZ_HI    = 16'h00FF;
  localparam logic [15:0] ROM1A_LO = 16'h8000;
  localparam logic [15:0] ROM1A_HI = 16'hFDFF;
  localparam logic [15:0] ROM1B_LO = 16'hFFCC;
  localparam logic [15:0] ROM1B_HI = 16'hFFFF;
  localparam logic [15:0] ROM2A_LO = 16'h0450;
  localparam logic [15:0] ROM2A_HI = 16'h04FF;
  localparam logic [15:0] ROM2B_LO = 16'h0580;
  localparam logic [15:0] ROM2B_HI = 16'h05FF;
  localparam logic [15:0] ROM2C_LO = 16'h0E00;
  localparam logic [15:0] ROM2C_HI = 16'h7FFF;

  // ==========================================================================
  // Stack sequencer states
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_PUSH = 2'b01,
    SAR_PULL = 2'b10
  } sar_state_t;

  // Stack operation requests from the core
  typedef enum logic [2:0] {
    SAR_OP_NONE = 3'b000,
    SAR_OP_IRQ  = 3'b001,
    SAR_OP_RTI  = 3'b010,
    SAR_OP_JSR  = 3'b011,
    SAR_OP_RTS  = 3'b100
  } sar_op_t;

endpackage : sar_pkg

// File: logic/sar_rom_if.sv
`timescale 1ns/1ps
`default_nettype none
// Per-array signals between the top and one array controller
interface sar_rom_if;
  logic hit;
  logic stop_req;
  logic rd_en;
  logic standby;
  logic viewable;
  modport ctl (input hit, input stop_req, output rd_en, output standby, output viewable);
  modport top (output hit, output stop_req, input rd_en, input standby, input viewable);
endinterface : sar_rom_if
`default_nettype wire

// File: logic/sar_rom_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// Read-only array control: read access, stop standby, view lockout
module sar_rom_ctl (
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  input  wire logic  secure_lock,
  input  wire logic  ext_view,
  sar_rom_if.ctl     rom
);
  logic standby_r;
  logic standby_nxt;

  // ==========================================================================
  // Standby entered only on stop; wait leaves the array running
  assign standby_nxt = rom.stop_req;
  always_ff @(posedge sys_clk) begin
    if (!rstn) standby_r <= 1'b0;
    else       standby_r <= standby_nxt;
  end

  assign rom.standby  = standby_r;
  assign rom.rd_en    = rom.hit & ~standby_r;
  // External viewing blocked whenever the lock is armed
  assign rom.viewable = ~(secure_lock & ext_view);
endmodule : sar_rom_ctl
`default_nettype wire

// File: logic/sar_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Stack pointer resets to 0x00FF, top of page-zero RAM.
// - Interrupt entry stacks exactly five bytes before handler fetch.
// - Upper index byte is neither pushed on interrupt nor pulled on return.
// - Subroutine call pushes two return-address bytes; return pulls two.
// - Stack pointer decrements per push, increments per pull.
// - Page zero holds 176 RAM bytes reachable by direct addressing.
// - First array decodes 0x8000-0xFDFF and vectors 0xFFCC-0xFFFF.
// - Second array decodes 0x0450-0x04FF, 0x0580-0x05FF, 0x0E00-0x7FFF.
// - Wait mode leaves arrays in read mode fully operational.
// - Stop mode puts reading arrays into low-power standby.
// - Protection blocks unauthorized external viewing of array contents.
// - Stack pointer is 16 bits, usable anywhere in 64K.
// - RAM selected at 0x0050-0x044F and 0x0A00-0x0DFF.
module sar_top (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [2:0]   stack_op,
  input  wire logic         sp_load,
  input  wire logic [15:0]  sp_load_val,
  input  wire logic [15:0]  addr,
  input  wire logic         wait_mode,
  input  wire logic         stop_mode,
  input  wire logic         secure_lock,
  input  wire logic         ext_view,
  output logic [15:0]       sp,
  output logic [15:0]       stack_addr,
  output logic              stack_strobe,
  output logic              stack_write,
  output logic [2:0]        stack_index,
  output logic              stack_busy,
  output logic              stack_done,
  output logic              ram_sel,
  output logic              page0_ram_sel,
  output logic              rom1_sel,
  output logic              rom2_sel,
  output logic              rom1_standby,
  output logic              rom2_standby,
  output logic              rom1_viewable,
  output logic              rom2_viewable
);

  // ==========================================================================
  // Sequencer state, stack pointer and frame counters
  // The pointer is a full 16-bit register so a reload can move the stack anywhere;
  // keeping it inside RAM is left to software, nothing here checks it
  sar_pkg::sar_state_t state_r;
  sar_pkg::sar_state_t state_nxt;
  logic [15:0]         sp_r;
  logic [15:0]         sp_nxt;
  logic [2:0]          cnt_r;
  logic [2:0]          cnt_nxt;
  logic [2:0]          idx_r;
  logic [2:0]          idx_nxt;
  logic                done_r;
  logic                done_nxt;
  logic                idle;
  logic                start_push;
  logic                start_pull;
  logic [2:0]          start_len;
  logic                last_byte;

  // ==========================================================================
  // Request decode; only taken while idle
  assign idle       = (state_r == sar_pkg::SAR_IDLE);
  assign start_push = idle & ((stack_op == sar_pkg::SAR_OP_IRQ) |
                              (stack_op == sar_pkg::SAR_OP_JSR));
  assign start_pull = idle & ((stack_op == sar_pkg::SAR_OP_RTI) |
                              (stack_op == sar_pkg::SAR_OP_RTS));
  // Interrupt frame is five bytes; the upper index byte is left out
  assign start_len  = ((stack_op == sar_pkg::SAR_OP_IRQ) |
                       (stack_op == sar_pkg::SAR_OP_RTI)) ?
                      sar_pkg::IRQ_STACK_BYTES :
                      sar_pkg::JSR_STACK_BYTES;
  // Counter holds the bytes still to move, so one left means last
  assign last_byte  = (cnt_r == 3'h1);

  // ==========================================================================
  // Stack sequencer: one byte per cycle, pointer moves with each byte
  always_comb begin
    state_nxt = state_r;
    sp_nxt    = sp_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    done_nxt  = 1'b0;
    case (state_r)
      sar_pkg::SAR_IDLE: begin
        // A pointer reload wins over a frame request in the same cycle
        idx_nxt = 3'h0;
        if (sp_load) begin
          sp_nxt = sp_load_val;
        end else if (start_push) begin
          state_nxt = sar_pkg::SAR_PUSH;
          cnt_nxt   = start_len;
        end else if (start_pull) begin
          state_nxt = sar_pkg::SAR_PULL;
          cnt_nxt   = start_len;
        end
      end
      sar_pkg::SAR_PUSH: begin
        // Write at SP then decrement, so the first byte pushed after reset lands at 0x00FF
        sp_nxt  = sp_r - 16'h0001;
        cnt_nxt = cnt_r - 3'h1;
        idx_nxt = idx_r + 3'h1;
        if (last_byte) begin
          state_nxt = sar_pkg::SAR_IDLE;
          done_nxt  = 1'b1;
        end
      end
      sar_pkg::SAR_PULL: begin
        // Pull reads at SP+1 then increments, undoing the push order
        sp_nxt  = sp_r + 16'h0001;
        cnt_nxt = cnt_r - 3'h1;
        idx_nxt = idx_r + 3'h1;
        if (last_byte) begin
          state_nxt = sar_pkg::SAR_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        // Unused code: recover to idle rather than lock up
        state_nxt = sar_pkg::SAR_IDLE;
      end
    endcase
  end


  // Registers; pointer reset puts the stack at the top of page zero
  // Counters clear too, so a frame cut by reset never resumes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= sar_pkg::SAR_IDLE;
      sp_r    <= sar_pkg::SP_RESET;
      cnt_r   <= 3'h0;
      idx_r   <= 3'h0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sp_r    <= sp_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
      done_r  <= done_nxt;
    end
  end


  // Pull reads at SP+1 (pre-increment); push writes at SP
  // Strobe and busy are the same term; both are kept so the core can use
  // busy as a stall and strobe as a memory request without extra decode
  assign sp           = sp_r;
  assign stack_addr   = (state_r == sar_pkg::SAR_PULL) ? (sp_r + 16'h0001) : sp_r;
  assign stack_strobe = ~idle;
  assign stack_write  = (state_r == sar_pkg::SAR_PUSH);
  assign stack_index  = idx_r;
  assign stack_busy   = ~idle;
  assign stack_done   = done_r;

  // ==========================================================================
  // Address decode; ranges are disjoint
  // Full 16-bit compares are used: a mask decode would be smaller, but the
  // window edges do not fall on power-of-two boundaries
  logic in_ram0;
  logic in_ram1;
  logic hit_rom1;
  logic hit_rom2;
  assign in_ram0       = (addr >= sar_pkg::RAM0_LO) && (addr <= sar_pkg::RAM0_HI);
  assign in_ram1       = (addr >= sar_pkg::RAM1_LO) && (addr <= sar_pkg::RAM1_HI);
  assign ram_sel       = in_ram0 | in_ram1;
  // 0x0050..0x00FF is the 176-byte direct-page RAM
  assign page0_ram_sel = in_ram0 && (addr <= sar_pkg::PZ_HI);
  assign hit_rom1 = ((addr >= sar_pkg::ROM1A_LO) && (addr <= sar_pkg::ROM1A_HI)) ||
                    ((addr >= sar_pkg::ROM1B_LO) && (addr <= sar_pkg::ROM1B_HI));
  assign hit_rom2 = ((addr >= sar_pkg::ROM2A_LO) && (addr <= sar_pkg::ROM2A_HI)) ||
                    ((addr >= sar_pkg::ROM2B_LO) && (addr <= sar_pkg::ROM2B_HI)) ||
                    ((addr >= sar_pkg::ROM2C_LO) && (addr <= sar_pkg::ROM2C_HI));

  // ==========================================================================
  // Array controllers; wait mode is deliberately not routed to them
  // Both arrays share stop and protection inputs but keep separate standby
  // flops, so each can be parked on its own if the modes ever diverge
  sar_rom_if rom1_if ();
  sar_rom_if rom2_if ();
  assign rom1_if.hit      = hit_rom1;
  assign rom2_if.hit      = hit_rom2;
  assign rom1_if.stop_req = stop_mode;
  assign rom2_if.stop_req = stop_mode;

  sar_rom_ctl u_rom1 (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .secure_lock (secure_lock),
    .ext_view    (ext_view),
    .rom         (rom1_if)
  );
  sar_rom_ctl u_rom2 (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .secure_lock (secure_lock),
    .ext_view    (ext_view),
    .rom         (rom2_if)
  );


  // Select is gated by standby; wait_mode has no effect here
  // Wait is taken only to make the intent visible: the halted core is what
  // stops array traffic, so no gating is wanted on this input
  logic unused_wait;
  assign unused_wait   = wait_mode;
  assign rom1_sel      = rom1_if.rd_en;
  assign rom2_sel      = rom2_if.rd_en;
  assign rom1_standby  = rom1_if.standby;
  assign rom2_standby  = rom2_if.standby;
  assign rom1_viewable = rom1_if.viewable;
  assign rom2_viewable = rom2_if.viewable;

endmodule : sar_top
`default_nettype wire

// File: sim/sar_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Stack and decode checker
module sar_top_sva (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [2:0]  stack_op,
  input wire logic        sp_load,
  input wire logic [15:0] addr,
  input wire logic        stop_mode,
  input wire logic        secure_lock,
  input wire logic        ext_view,
  input wire logic [15:0] sp,
  input wire logic        stack_strobe,
  input wire logic        stack_write,
  input wire logic        stack_busy,
  input wire logic        stack_done,
  input wire logic        ram_sel,
  input wire logic        page0_ram_sel,
  input wire logic        rom1_sel,
  input wire logic        rom2_standby,
  input wire logic        rom1_standby,
  input wire logic        rom2_viewable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // A request counts only when the sequencer is free
  wire take = !stack_busy && !sp_load;
  sequence irq_frame_s;
    (stack_strobe && stack_write)[*5] ##1 stack_done;
  endsequence
  sequence call_frame_s;
    (stack_strobe && stack_write)[*2] ##1 stack_done;
  endsequence
  sequence rti_frame_s;
    (stack_strobe && !stack_write)[*5] ##1 stack_done;
  endsequence
  sequence ret_frame_s;
    (stack_strobe && !stack_write)[*2] ##1 stack_done;
  endsequence
  sp_reset_a: assert property (disable iff (1'b0) !rstn |=> sp == 16'h00FF)
    else $error("sp not at reset value");
  irq_frame_a: assert property (take && stack_op == 3'h1 |=> irq_frame_s)
    else $error("interrupt frame length wrong");
  call_frame_a: assert property (take && stack_op == 3'h3 |=> call_frame_s)
    else $error("call frame length wrong");
  rti_frame_a: assert property (take && stack_op == 3'h2 |=> rti_frame_s)
    else $error("interrupt return length wrong");
  ret_frame_a: assert property (take && stack_op == 3'h4 |=> ret_frame_s)
    else $error("return frame length wrong");
  sp_step_a: assert property (stack_strobe |=>
    sp == ($past(stack_write) ? $past(sp) - 16'h0001 : $past(sp) + 16'h0001))
    else $error("sp step wrong");
  ram_dec_a: assert property (ram_sel == ((addr >= 16'h0050 && addr <= 16'h044F)
    || (addr >= 16'h0A00 && addr <= 16'h0DFF))) else $error("ram decode wrong");
  page0_dec_a: assert property (page0_ram_sel == (addr >= 16'h0050 && addr <= 16'h00FF))
    else $error("page zero decode wrong");
  rom1_dec_a: assert property (!rom1_standby |-> rom1_sel ==
    ((addr >= 16'h8000 && addr <= 16'hFDFF) || addr >= 16'hFFCC)) else $error("rom1 decode");
  stop_sb_a: assert property ($past(rstn) |-> rom2_standby == $past(stop_mode))
    else $error("standby does not follow stop");
  view_lock_a: assert property (rom2_viewable == !(secure_lock && ext_view))
    else $error("view lockout wrong");
endmodule : sar_top_sva
bind sar_top sar_top_sva u_sva (.sys_clk, .rstn, .stack_op, .sp_load, .addr, .stop_mode,
  .secure_lock, .ext_view, .sp, .stack_strobe, .stack_write, .stack_busy, .stack_done,
  .ram_sel, .page0_ram_sel, .rom1_sel, .rom2_standby, .rom1_standby, .rom2_viewable);
`default_nettype wire

// File: sim/sar_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Core model: one stack request at a time, held for a single edge
module sar_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic [2:0] op,
  input  wire logic       stack_done,
  output logic [2:0]      stack_op,
  output logic            idle
);
  // Never re-issue before done, since a busy sequencer drops requests silently
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stack_op <= 3'h0;
      idle     <= 1'b1;
    end else if (go && idle) begin
      stack_op <= op;
      idle     <= 1'b0;
    end else begin
      stack_op <= 3'h0;
      if (stack_done) idle <= 1'b1;
    end
  end
endmodule : sar_cpu_model
`default_nettype wire

// File: sim/tb_sar_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sar_top;
  logic        sys_clk, rstn, sp_load, wait_mode, stop_mode, secure_lock, ext_view, go, idle;
  logic        stack_strobe, stack_write, stack_busy, stack_done, ram_sel, page0_ram_sel;
  logic        rom1_sel, rom2_sel, rom1_standby, rom2_standby, rom1_viewable, rom2_viewable;
  logic [2:0]  op, stack_op, stack_index;
  logic [15:0] sp_load_val, addr, sp, stack_addr;
  logic [15:0] corner [20] = '{16'h004F, 16'h0100, 16'h044F, 16'h04FF, 16'h057F, 16'h05FF,
                               16'h09FF, 16'h0DFF, 16'h7FFF, 16'hFDFF, 16'hFFCB, 16'hFFCC,
                               16'h0050, 16'h00FF, 16'h0450, 16'h0580, 16'h0A00, 16'h0E00,
                               16'h8000, 16'hFFFF};
  int          n_mismatch, num_checks, cyc, seed;
  sar_top dut (.sys_clk, .rstn, .stack_op, .sp_load, .sp_load_val, .addr, .wait_mode,
    .stop_mode, .secure_lock, .ext_view, .sp, .stack_addr, .stack_strobe, .stack_write,
    .stack_index, .stack_busy, .stack_done, .ram_sel, .page0_ram_sel, .rom1_sel, .rom2_sel,
    .rom1_standby, .rom2_standby, .rom1_viewable, .rom2_viewable);
  sar_cpu_model cpu (.sys_clk, .rstn, .go, .op, .stack_done, .stack_op, .idle);
  // ==========================================================================
  // Clock, timeout and reporting
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Expected decode as {ram, page0, rom1, rom2}
  function automatic logic [3:0] exp_dec(input logic [15:0] a);
    return {(a >= 16'h0050 && a <= 16'h044F) || (a >= 16'h0A00 && a <= 16'h0DFF),
            a >= 16'h0050 && a <= 16'h00FF, (a >= 16'h8000 && a <= 16'hFDFF) || a >= 16'hFFCC,
            (a >= 16'h0450 && a <= 16'h04FF) || (a >= 16'h0580 && a <= 16'h05FF)
            || (a >= 16'h0E00 && a <= 16'h7FFF)};
  endfunction : exp_dec
  // One stack frame; odd codes push, frame is five bytes for interrupt codes
  task automatic run_op(input logic [2:0] o);
    logic [15:0] s0, first;
    int          n, k;
    s0 = sp;
    n = (o < 3'h3) ? 5 : 2;
    k = 0;
    first = 16'h0000;
    @(posedge sys_clk);
    go <= 1'b1;
    op <= o;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i < 20 && stack_done !== 1'b1; i++) begin
      @(negedge sys_clk);
      if (stack_strobe === 1'b1) begin
        if (k == 0) first = stack_addr;
        chk("byte addr", o[0] ? s0 - 16'(k) : s0 + 16'(k + 1), stack_addr);
        chk("byte index", 16'(k), {13'h0000, stack_index});
        k++;
      end
    end
    chk("stack bytes", 16'(n), 16'(k));
    chk("first addr", o[0] ? s0 : s0 + 16'h0001, first);
    chk("sp after", o[0] ? s0 - 16'(n) : s0 + 16'(n), sp);
  endtask : run_op
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'hed42a92e;
    {rstn, sp_load, wait_mode, stop_mode, secure_lock, ext_view, go, op} = '0;
    sp_load_val = 16'h0000;
    addr = 16'h0000;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk("sp reset", 16'h00FF, sp);
    for (int o = 1; o <= 4; o++) run_op(3'(o));
    @(posedge sys_clk);
    sp_load <= 1'b1;
    sp_load_val <= 16'h0440;
    @(posedge sys_clk);
    sp_load <= 1'b0;
    @(negedge sys_clk);
    chk("sp load", 16'h0440, sp);
    // Random frames, some back to back, some after a slow core
    for (int i = 0; i < 40; i++) begin
      run_op(3'(($random(seed) & 3) + 1));
      repeat ($random(seed) & 3) @(posedge sys_clk);
    end
    for (int i = 0; i < 300; i++) begin
      @(posedge sys_clk);
      addr <= (i < 20) ? corner[i] : 16'($random(seed));
      wait_mode <= 1'($random(seed));
      @(negedge sys_clk);
      chk("decode", {12'h000, exp_dec(addr)},
          {12'h000, ram_sel, page0_ram_sel, rom1_sel, rom2_sel});
    end
    // Stop mode parks both arrays and hides their selects
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    addr <= 16'h8000;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("standby", 16'h0006, {13'h0000, rom1_standby, rom2_standby, rom1_sel});
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {secure_lock, ext_view} <= 2'(i);
      stop_mode <= 1'b0;
      @(negedge sys_clk);
      chk("viewable", {14'h0000, {2{i != 3}}}, {14'h0000, rom1_viewable, rom2_viewable});
    end
    tally_and_finish();
  end
endmodule : tb_sar_top
`default_nettype wire
